//--- rtl/lrp_top.sv
// Added by the designer: the address map and the Avalon-MM register port.
module lrp_top import lrp_pkg::*; #(
    parameter int unsigned INIT_CYCLES = INIT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon register bus
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // device pins
    input wire logic reset_pin,
    input wire logic sleep_request_pin,
    input wire logic osc_pin_tied_high,
    // status and drive
    output logic busy_flag,
    output logic internal_osc_sel,
    output logic internal_osc_run,
    output logic bias_en,
    output logic lcd_drive_en,
    output logic lcd_frame_phase,
    output logic frame_tick,
    output logic clear_display_active,
    output logic i2c_reset,
    // control state
    output logic [CTRL_W-1:0] control_state,
    output logic [SUP_W-1:0] supply_code_op
);
    localparam logic [CNT_W-1:0] CLEAR_LAST = CNT_W'(CLEAR_CYC - 1);
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(INIT_CYCLES - CLEAR_CYC - 1);
    localparam logic [CNT_W-1:0] HOLD_MIN = CNT_W'(RESET_MIN_CYC);

    lrp_bus_if bus ();

    lrp_state_e state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic busy_q, clear_q, i2c_q;
    logic osc_sel_q, osc_run_q, bias_q, drive_q, phase_q;
    logic [CTRL_W-1:0] ctrl_q, ctrl_d;
    logic [SUP_W-1:0] vc_char_q, vc_char_d, vc_icon_q, vc_icon_d, code_q;
    logic div_phase;
    logic [FCNT_W-1:0] frame_cnt;

    lrp_avmm_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .address(avs_address),
        .read(avs_read),
        .write(avs_write),
        .writedata(avs_writedata),
        .readdata(avs_readdata),
        .waitrequest(avs_waitrequest),
        .bus(bus.slave)
    );

    // internal oscillator stops in sleep; an external clock keeps the divider going
    wire div_run = !(sleep_request_pin && osc_sel_q);

    // divider has no bus input, so host traffic cannot upset refresh
    lrp_frame_div u_div (
        .clk(clk),
        .rst_n(rst_n),
        .run(div_run),
        .frame_tick(frame_tick),
        .frame_phase(div_phase),
        .frame_count(frame_cnt)
    );

    // reset sequencing
    wire hold_ok = cnt_q >= HOLD_MIN;
    // a minimum-length pulse is only known good at its release edge, so load there too
    wire load_defaults = (state_q == LRP_HOLD) && hold_ok;
    wire [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_inc;
        unique case (state_q)
            LRP_IDLE: begin
                cnt_d = '0;
            end
            LRP_HOLD: begin
                if (hold_ok) begin
                    cnt_d = cnt_q;
                end
                if (!reset_pin) begin
                    state_d = hold_ok ? LRP_CLEAR : LRP_IDLE;
                    cnt_d = '0;
                end
            end
            LRP_CLEAR: begin
                if (cnt_q == CLEAR_LAST) begin
                    state_d = LRP_SETTLE;
                    cnt_d = '0;
                end
            end
            LRP_SETTLE: begin
                if (cnt_q == SETTLE_LAST) begin
                    state_d = LRP_IDLE;
                    cnt_d = '0;
                end
            end
        endcase
        if (reset_pin && state_q != LRP_HOLD) begin
            state_d = LRP_HOLD;
            cnt_d = CNT_W'(1);
        end
    end

    // register writes; defaults win, and a busy device ignores the host
    wire hit_ctrl = lrp_hit(bus.addr, REG_CTRL);
    wire hit_sup = lrp_hit(bus.addr, REG_SUPPLY);
    wire hit_stat = lrp_hit(bus.addr, REG_STATUS);
    wire hit_frame = lrp_hit(bus.addr, REG_FRAME);
    wire wr_ok = bus.wr_stb && !busy_q;
    wire wr_ctrl = wr_ok && hit_ctrl;
    wire wr_sup = wr_ok && hit_sup;

    // sleep does not touch any of these, so state survives power-down
    assign ctrl_d = load_defaults ? CTRL_RST :
        wr_ctrl ? bus.wdata[CTRL_W-1:0] : ctrl_q;
    assign vc_char_d = load_defaults ? SUP_RST :
        wr_sup ? bus.wdata[SUP_CHAR_LSB +: SUP_W] : vc_char_q;
    assign vc_icon_d = load_defaults ? SUP_RST :
        wr_sup ? bus.wdata[SUP_ICON_LSB +: SUP_W] : vc_icon_q;

    // read side
    wire [31:0] status_word = (32'(busy_q) << ST_BUSY_BIT)
        | (32'(clear_q) << ST_CLEAR_BIT)
        | (32'(osc_sel_q) << ST_INTOSC_BIT)
        | (32'(sleep_request_pin) << ST_SLEEP_BIT);
    wire [31:0] sup_word = (32'(vc_char_q) << SUP_CHAR_LSB) | (32'(vc_icon_q) << SUP_ICON_LSB);
    assign bus.rdata = hit_ctrl ? 32'(ctrl_q) :
        hit_sup ? sup_word :
        hit_stat ? status_word :
        hit_frame ? 32'(frame_cnt) : 32'h0;

    wire [SUP_W-1:0] code_sel = ctrl_q[ICON_ONLY_BIT] ? vc_icon_q : vc_char_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= LRP_IDLE;
            cnt_q <= '0;
            busy_q <= 1'b0;
            clear_q <= 1'b0;
            i2c_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            busy_q <= state_d != LRP_IDLE;
            clear_q <= state_d == LRP_CLEAR;
            i2c_q <= state_d == LRP_HOLD;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RST;
            vc_char_q <= SUP_RST;
            vc_icon_q <= SUP_RST;
        end else begin
            ctrl_q <= ctrl_d;
            vc_char_q <= vc_char_d;
            vc_icon_q <= vc_icon_d;
        end
    end

    // pin-facing drive, all low while sleeping except osc_sel_q, which follows osc_pin_tied_high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_sel_q <= 1'b1;
            osc_run_q <= 1'b0;
            bias_q <= 1'b0;
            drive_q <= 1'b0;
            phase_q <= 1'b0;
            code_q <= SUP_RST;
        end else begin
            osc_sel_q <= osc_pin_tied_high;
            osc_run_q <= osc_pin_tied_high && !sleep_request_pin;
            bias_q <= !sleep_request_pin;
            drive_q <= !sleep_request_pin;
            phase_q <= div_phase && !sleep_request_pin;
            code_q <= sleep_request_pin ? SUP_RST : code_sel;
        end
    end

    assign busy_flag = busy_q;
    assign clear_display_active = clear_q;
    assign i2c_reset = i2c_q;
    assign internal_osc_sel = osc_sel_q;
    assign internal_osc_run = osc_run_q;
    assign bias_en = bias_q;
    assign lcd_drive_en = drive_q;
    assign lcd_frame_phase = phase_q;
    assign control_state = ctrl_q;
    assign supply_code_op = code_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_HOLD_MIN: assert property (
        state_q == LRP_HOLD && !reset_pin && cnt_q < HOLD_MIN |=> state_q == LRP_IDLE)
        else $error("short reset pulse started a reset sequence");
    AST_CLEAR_EXIT: assert property (
        state_q == LRP_CLEAR && cnt_q == CLEAR_LAST && !reset_pin |=> state_q == LRP_SETTLE)
        else $error("clear step did not end after 165 cycles");
    AST_CLEAR_FLAG: assert property ($rose(clear_q) |-> $past(state_q) == LRP_HOLD)
        else $error("clear step started other than from reset release");
    AST_BUSY_END: assert property ($fell(busy_q) |->
        ($past(state_q) == LRP_SETTLE && $past(cnt_q) == SETTLE_LAST) || $past(state_q) == LRP_HOLD)
        else $error("busy flag cleared before initialisation time");
    AST_BUSY_INIT: assert property (
        state_q == LRP_CLEAR || state_q == LRP_SETTLE |-> busy_q)
        else $error("busy flag low during initialisation");
    AST_DEFAULTS: assert property (load_defaults |=>
        ctrl_q == CTRL_RST && vc_char_q == SUP_RST && vc_icon_q == SUP_RST)
        else $error("control state not at reset defaults");
    AST_SLEEP_DRIVE: assert property (sleep_request_pin |=>
        !lcd_drive_en && !bias_en && !internal_osc_run && !lcd_frame_phase)
        else $error("outputs still driven in power-down");
    AST_RETAIN: assert property (
        sleep_request_pin && !wr_ctrl && !load_defaults |=> $stable(ctrl_q))
        else $error("control state lost during power-down");
    AST_SLEEP_WRITE: assert property (
        sleep_request_pin && wr_ctrl && !load_defaults |=> ctrl_q == $past(bus.wdata[CTRL_W-1:0]))
        else $error("instruction not executed in power-down");
    AST_REFUSE: assert property (bus.wr_stb && busy_q && !load_defaults |=>
        $stable(ctrl_q) && $stable(vc_char_q) && $stable(vc_icon_q))
        else $error("write accepted while busy");
    AST_STATUS_MSB: assert property (
        bus.rd_stb && hit_stat |-> bus.rdata[ST_BUSY_BIT] == busy_q)
        else $error("busy flag missing from status");
    AST_I2C_IDLE: assert property (load_defaults |-> i2c_q)
        else $error("i2c logic not held idle during reset");

    COV_INIT_DONE: cover property (state_q == LRP_SETTLE ##1 state_q == LRP_IDLE);
    COV_SLEEP_WRITE: cover property (sleep_request_pin && wr_ctrl);
    COV_REFUSED: cover property (bus.wr_stb && busy_q);
endmodule

//--- rtl/lrp_pkg.sv
package lrp_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned FRAME_DIV = 3072;
    localparam int unsigned FDIV_W = 12;
    localparam logic [FDIV_W-1:0] FRAME_LAST = FDIV_W'(FRAME_DIV - 1);
    localparam int unsigned CLEAR_CYC = 165;
    localparam int unsigned INIT_TIME_MS = 2;
    localparam int unsigned INIT_CYC = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int unsigned RESET_MIN_CYC = 3;
    localparam int unsigned CNT_W = 20;
    localparam int unsigned FCNT_W = 16;

    // avalon byte addresses, one word each
    localparam int unsigned ADDR_W = 4;
    localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] REG_SUPPLY = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] REG_FRAME = 4'hc;

    // control word layout
    localparam int unsigned CTRL_W = 19;
    localparam int unsigned SHIFT_BIT = 0;
    localparam int unsigned INCR_BIT = 1;
    localparam int unsigned BLINK_BIT = 2;
    localparam int unsigned CURSOR_BIT = 3;
    localparam int unsigned DISPLAY_BIT = 4;
    localparam int unsigned EXT_SET_BIT = 5;
    localparam int unsigned MUX_RATE_BIT = 6;
    localparam int unsigned TWO_LINE_BIT = 7;
    localparam int unsigned BUS_WIDTH_BIT = 8;
    localparam int unsigned CGRAM_SEL_BIT = 9;
    localparam int unsigned ICON_BLINK_BIT = 10;
    localparam int unsigned ICON_ONLY_BIT = 11;
    localparam int unsigned SCREEN_CONF_BIT = 12;
    localparam int unsigned DISP_CONF_Q_BIT = 13;
    localparam int unsigned DISP_CONF_P_BIT = 14;
    localparam int unsigned TEMP_COEF_LOWER_BIT = 15;
    localparam int unsigned TEMP_COEF_UPPER_BIT = 16;
    localparam int unsigned STAGE_LOWER_BIT = 17;
    localparam int unsigned STAGE_UPPER_BIT = 18;
    localparam logic [CTRL_W-1:0] CTRL_RST = 19'h40102;

    // supply code layout
    localparam int unsigned SUP_W = 6;
    localparam int unsigned SUP_CHAR_LSB = 0;
    localparam int unsigned SUP_ICON_LSB = 8;
    localparam logic [SUP_W-1:0] SUP_RST = 6'h00;

    // status layout
    localparam int unsigned ST_SLEEP_BIT = 0;
    localparam int unsigned ST_INTOSC_BIT = 1;
    localparam int unsigned ST_CLEAR_BIT = 2;
    localparam int unsigned ST_BUSY_BIT = 7;

    typedef enum logic [1:0] {
        LRP_IDLE = 2'b00,
        LRP_HOLD = 2'b01,
        LRP_CLEAR = 2'b11,
        LRP_SETTLE = 2'b10
    } lrp_state_e;

    function automatic logic lrp_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
        return addr == off;
    endfunction
endpackage

//--- rtl/lrp_bus_if.sv
interface lrp_bus_if;
    logic wr_stb;
    logic rd_stb;
    logic [3:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    modport slave(output wr_stb, output rd_stb, output addr, output wdata, input rdata);
    modport regs(input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface

//--- rtl/lrp_avmm_slave.sv
module lrp_avmm_slave import lrp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // avalon side
    input wire logic [ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // register side
    lrp_bus_if.slave bus
);
    logic wait_q, wait_d;
    logic [31:0] rdata_q;
    wire req = read | write;

    // one wait cycle per access; data captured while still waiting
    assign wait_d = !(req && wait_q);
    assign bus.wr_stb = write && !wait_q;
    assign bus.rd_stb = read && wait_q;
    assign bus.addr = address;
    assign bus.wdata = writedata;
    assign readdata = rdata_q;
    assign waitrequest = wait_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q <= wait_d;
            if (bus.rd_stb) begin
                rdata_q <= bus.rdata;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_WAIT_ONE: assert property (req && wait_q |=> !wait_q)
        else $error("waitrequest not released after one cycle");
    AST_WAIT_BACK: assert property (!wait_q |=> wait_q)
        else $error("waitrequest low for more than one cycle");
endmodule

//--- rtl/lrp_frame_div.sv
module lrp_frame_div import lrp_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    // frame timing
    output logic frame_tick,
    output logic frame_phase,
    output logic [FCNT_W-1:0] frame_count
);
    logic [FDIV_W-1:0] div_q;
    logic tick_q, phase_q;
    logic [FCNT_W-1:0] fcnt_q;
    wire wrap = run && (div_q == FRAME_LAST);

    assign frame_tick = tick_q;
    assign frame_phase = phase_q;
    assign frame_count = fcnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
            tick_q <= 1'b0;
            phase_q <= 1'b0;
            fcnt_q <= '0;
        end else begin
            tick_q <= wrap;
            if (run) begin
                div_q <= wrap ? '0 : div_q + 1'b1;
            end
            if (wrap) begin
                phase_q <= !phase_q;
                fcnt_q <= fcnt_q + 1'b1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_FRAME_PERIOD: assert property (tick_q |-> $past(div_q) == FRAME_LAST)
        else $error("frame tick not at end of 3072-cycle period");
    COV_FRAME: cover property (tick_q ##1 !tick_q);
endmodule

//--- test/lrp_host_model.sv
module lrp_host_model (
    // clock
    input wire logic clk,
    // device pins
    output logic reset_pin,
    output logic sleep_request_pin,
    output logic osc_pin_tied_high
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reset_pin = 1'b0;
        sleep_request_pin = 1'b0;
        osc_pin_tied_high = 1'b1;
    end

    // pulses under three edges are used on purpose to probe the ignore path
    task automatic hold_reset(input int n);
        @(posedge clk);
        reset_pin <= 1'b1;
        repeat (n) @(posedge clk);
        reset_pin <= 1'b0;
    endtask

    // clock never stops here, so the frozen-drive hazard cannot arise
    task automatic set_sleep(input logic v);
        @(posedge clk);
        sleep_request_pin <= v;
    endtask

    task automatic set_osc(input logic v);
        @(posedge clk);
        osc_pin_tied_high <= v;
    endtask
endmodule

//--- test/lrp_top_test.sv
module lrp_top_test import lrp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned INIT_T = 200;
    logic clk;
    logic rst_n;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, reset_pin, sleep_request_pin, osc_pin_tied_high;
    logic busy_flag, internal_osc_sel, internal_osc_run, bias_en, lcd_drive_en;
    logic lcd_frame_phase, frame_tick, clear_display_active, i2c_reset;
    logic [CTRL_W-1:0] control_state;
    logic [SUP_W-1:0] supply_code_op;
    int bad_count = 0;
    int cmp_count = 0;
    logic [31:0] rd;
    int n, clr, bsy;

    always #2 clk = ~clk;

    lrp_host_model host (.clk(clk), .reset_pin(reset_pin),
        .sleep_request_pin(sleep_request_pin), .osc_pin_tied_high(osc_pin_tied_high));

    lrp_top #(.INIT_CYCLES(INIT_T)) dut (.clk(clk), .rst_n(rst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .reset_pin(reset_pin),
        .sleep_request_pin(sleep_request_pin), .osc_pin_tied_high(osc_pin_tied_high),
        .busy_flag(busy_flag), .internal_osc_sel(internal_osc_sel),
        .internal_osc_run(internal_osc_run), .bias_en(bias_en), .lcd_drive_en(lcd_drive_en),
        .lcd_frame_phase(lcd_frame_phase), .frame_tick(frame_tick),
        .clear_display_active(clear_display_active), .i2c_reset(i2c_reset),
        .control_state(control_state), .supply_code_op(supply_code_op));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until the edge that samples waitrequest low
    task automatic av_xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        rd = avs_readdata;
        if (k >= 50) check("waitrequest", avs_waitrequest, 32'h0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_tick(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (frame_tick !== 1'b1 && k < 4000);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #(4 * 40000);
        bad_count++;
        give_verdict();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        check("ctrl after chip reset", control_state, CTRL_RST);
        av_xfer(1'b0, REG_CTRL, '0);
        check("ctrl read", rd, 32'(CTRL_RST));
        av_xfer(1'b0, REG_SUPPLY, '0);
        check("supply read", rd, 32'h0);
        av_xfer(1'b0, 4'h2, '0);
        check("unmapped read", rd, 32'h0);
        // frame spacing with bus traffic alongside
        fork
            begin
                wait_tick(n);
                wait_tick(n);
                check("frame period", n, 32'd3072);
            end
            repeat (30) av_xfer(1'b0, REG_FRAME, '0);
        join
        av_xfer(1'b1, REG_CTRL, 32'h00112);
        av_xfer(1'b1, REG_SUPPLY, 32'h0000152a);
        repeat (2) @(posedge clk);
        check("char code", supply_code_op, 32'h2a);
        host.set_sleep(1'b1);
        repeat (3) @(posedge clk);
        check("bias in sleep", bias_en, 32'h0);
        check("drive in sleep", lcd_drive_en, 32'h0);
        check("osc in sleep", internal_osc_run, 32'h0);
        check("phase in sleep", lcd_frame_phase, 32'h0);
        check("code in sleep", supply_code_op, 32'h0);
        clr = 0;
        repeat (3100) begin
            @(posedge clk);
            if (frame_tick === 1'b1) clr++;
        end
        check("ticks in sleep", clr, 32'h0);
        av_xfer(1'b1, REG_CTRL, 32'h00116);
        av_xfer(1'b0, REG_CTRL, '0);
        check("ctrl write in sleep", rd, 32'h00116);
        host.set_sleep(1'b0);
        repeat (3) @(posedge clk);
        check("code kept", supply_code_op, 32'h2a);
        check("bias back", bias_en, 32'h1);
        check("ctrl kept", control_state, 32'h00116);
        av_xfer(1'b1, REG_CTRL, 32'h00916);
        repeat (2) @(posedge clk);
        check("icon code", supply_code_op, 32'h15);
        host.set_osc(1'b0);
        repeat (3) @(posedge clk);
        check("osc select", internal_osc_sel, 32'h0);
        check("osc run", internal_osc_run, 32'h0);
        av_xfer(1'b0, REG_STATUS, '0);
        check("status osc", rd[ST_INTOSC_BIT], 32'h0);
        host.set_osc(1'b1);
        // short pulse must be ignored
        host.hold_reset(2);
        repeat (5) @(posedge clk);
        check("ctrl after short pulse", control_state, 32'h00916);
        // shortest legal pulse must still load the defaults
        fork
            host.hold_reset(3);
            begin
                repeat (3) @(posedge clk);
                check("busy in hold", busy_flag, 32'h1);
                check("i2c idle in hold", i2c_reset, 32'h1);
            end
        join
        clr = 0;
        bsy = 0;
        n = 0;
        while (n < 1000) begin
            @(posedge clk);
            n++;
            if (clear_display_active === 1'b1) clr++;
            if (clr > 0 && busy_flag === 1'b1) bsy++;
            if (clr > 0 && busy_flag !== 1'b1) break;
        end
        check("clear length", clr, 32'd165);
        check("busy length", bsy, INIT_T);
        check("ctrl defaults", control_state, CTRL_RST);
        check("code defaults", supply_code_op, 32'h0);
        check("i2c released", i2c_reset, 32'h0);
        host.hold_reset(4);
        av_xfer(1'b0, REG_STATUS, '0);
        check("status busy bit", rd[ST_BUSY_BIT], 32'h1);
        av_xfer(1'b1, REG_CTRL, 32'h00010);
        av_xfer(1'b0, REG_CTRL, '0);
        check("write while busy", rd, 32'(CTRL_RST));
        give_verdict();
    end
endmodule
